// ===== hdl/light_barrier_pulse_controller.sv
// digital core of a pulsed light barrier: led timing, filters, pin sharing
// Functional notes
// - chip select high means operation, low command
// - shared pins swap roles in command mode
// - standalone ignores enable, uses scan period
// - controlled mode pulses led per enable
// - led pulse length selectable 1 to 8us
// - scan period settable 5 to 100000us
// - controlled cycle time follows enable input
// - response within (valid count+1) cycles
// - release within (missing count+1) cycles
// - increment weight sets 1..32 valid pulses
// - decrement weight sets up to 32768 pulses
// - all timing from one reference clock
// - detection outputs are open drain
// - controlled pulse starts on synced enable rise
// - weighted saturating counter add and subtract
// - output low at max, high at zero
`include "light_barrier_cfg.svh"

module light_barrier_pulse_controller
#(
  parameter int CYC_PER_US = `LB_CLK_MHZ
)
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_cs_n,
  input  wire logic        i_en_si,
  input  wire logic        i_led_sck_i,
  output logic             o_led_sck_o,
  output logic             o_led_sck_oe_n,
  output logic             o_detect_out_n_o,
  output logic             o_detect_out_n_oe_n,
  output logic             o_reserve_out_n_o,
  output logic             o_reserve_out_n_oe_n,
  input  wire logic        i_standalone,
  input  wire logic [2:0]  i_led_pulse_len,
  input  wire logic [16:0] i_scan_period,
  input  wire logic [4:0]  i_inc_weight,
  input  wire logic [3:0]  i_missing_weight,
  input  wire logic        i_detect_hit,
  input  wire logic        i_reserve_hit,
  input  wire logic        i_serial_out,
  output logic             o_cmd_mode,
  output logic             o_serial_in,
  output logic             o_serial_clk_rise,
  output logic             o_pulse_strobe
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // time in microseconds to clock cycles at the core rate
  function automatic logic [23:0] to_cycles(input logic [16:0] us);
    logic [47:0] prod;
    prod      = 48'(us) * 48'(CYC_PER_US);
    to_cycles = prod[23:0];
  endfunction : to_cycles

  function automatic logic [16:0] clamp_period(input logic [16:0] us);
    if (us < 17'(`LB_PER_US_MIN))
      clamp_period = 17'(`LB_PER_US_MIN);
    else if (us > 17'(`LB_PER_US_MAX))
      clamp_period = 17'(`LB_PER_US_MAX);
    else
      clamp_period = us;
  endfunction : clamp_period

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] cs_sync_q;
  logic [1:0] en_sync_q;
  logic [1:0] sck_sync_q;
  logic       en_prev_q;
  logic       sck_prev_q;

  // cs and enable idle high through their pull-ups
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      cs_sync_q  <= 2'h3;
      en_sync_q  <= 2'h3;
      sck_sync_q <= 2'h0;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[0], i_cs_n};
      en_sync_q  <= {en_sync_q[0], i_en_si};
      sck_sync_q <= {sck_sync_q[0], i_led_sck_i};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      en_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      en_prev_q  <= en_sync_q[1];
      sck_prev_q <= sck_sync_q[1];
    end
  end

  logic op_mode;
  logic en_rise;
  logic sck_rise;

  assign op_mode  = cs_sync_q[1];
  assign en_rise  = en_sync_q[1] & ~en_prev_q;
  assign sck_rise = sck_sync_q[1] & ~sck_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // cycle timing

  logic [23:0] pulse_cyc;
  logic [23:0] period_cyc;

  // all periods derive from the core clock; a slow reference only
  // changes CYC_PER_US
  assign pulse_cyc  = to_cycles(17'(i_led_pulse_len) + 17'(`LB_PULSE_US_MIN));
  assign period_cyc = to_cycles(clamp_period(i_scan_period));

  logic [23:0] per_cnt_q;
  logic        per_tick;

  assign per_tick = (per_cnt_q == 24'h000000);

  // scan timer, free running in standalone operation and held at zero otherwise, reloaded on expiry
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      per_cnt_q <= 24'h000000;
    else if (!op_mode || !i_standalone)
      per_cnt_q <= 24'h000000;
    else if (per_tick)
      per_cnt_q <= period_cyc - 24'h000001;
    else
      per_cnt_q <= per_cnt_q - 24'h000001;
  end

  logic trigger;

  // standalone never looks at enable
  assign trigger = op_mode & (i_standalone ? per_tick : en_rise);

  ////////////////////////////////////////////////////////////////////////////
  // led pulse sequencer

  light_barrier_pkg::led_state_e state_q;
  light_barrier_pkg::led_state_e state_d;
  logic [23:0]                   pulse_cnt_q;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      light_barrier_pkg::ST_IDLE:
      begin
        if (trigger)
          state_d = light_barrier_pkg::ST_PULSE;
      end
      light_barrier_pkg::ST_PULSE:
      begin
        if (!op_mode)
          state_d = light_barrier_pkg::ST_IDLE;
        else if (pulse_cnt_q == 24'h000001)
          state_d = light_barrier_pkg::ST_EVAL;
      end
      light_barrier_pkg::ST_EVAL:
      begin
        state_d = light_barrier_pkg::ST_IDLE;
      end
      default:
      begin
        state_d = light_barrier_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      state_q <= light_barrier_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // a trigger during a running pulse is dropped, not queued
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      pulse_cnt_q <= 24'h000000;
    else if (state_q == light_barrier_pkg::ST_IDLE && trigger)
      pulse_cnt_q <= pulse_cyc;
    else if (state_q == light_barrier_pkg::ST_PULSE && pulse_cnt_q != 24'h000000)
      pulse_cnt_q <= pulse_cnt_q - 24'h000001;
    else
      pulse_cnt_q <= 24'h000000;
  end

  logic led_q;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      led_q <= 1'b0;
    else
      led_q <= (state_d == light_barrier_pkg::ST_PULSE);
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator sampling and filters

  logic strobe;
  logic det_active;
  logic res_active;

  // comparators are read once, at the end of each led pulse
  assign strobe = op_mode & (state_q == light_barrier_pkg::ST_EVAL);

  pulse_filter u_detect_filter
  (
    .i_clk            (i_clk),
    .i_rstn           (i_rstn),
    .i_strobe         (strobe),
    .i_valid          (i_detect_hit),
    .i_inc_weight     (i_inc_weight),
    .i_missing_weight (i_missing_weight),
    .o_active         (det_active),
    .o_count          ()
  );

  pulse_filter u_reserve_filter
  (
    .i_clk            (i_clk),
    .i_rstn           (i_rstn),
    .i_strobe         (strobe),
    .i_valid          (i_reserve_hit),
    .i_inc_weight     (i_inc_weight),
    .i_missing_weight (i_missing_weight),
    .o_active         (res_active),
    .o_count          ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared pins

  logic       so_q;
  logic       si_q;
  logic       sck_rise_q;
  logic       strobe_q;
  logic [2:0] cmd_age_q;

  // the clock synchroniser still carries the led level for a few cycles
  // after entry to command mode; a rise seen then is no host clock edge
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      cmd_age_q <= 3'h0;
    else if (op_mode)
      cmd_age_q <= 3'h0;
    else
      cmd_age_q <= {cmd_age_q[1:0], 1'b1};
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      so_q       <= 1'b1;
      si_q       <= 1'b1;
      sck_rise_q <= 1'b0;
      strobe_q   <= 1'b0;
    end
    else
    begin
      so_q       <= i_serial_out;
      si_q       <= en_sync_q[1];
      sck_rise_q <= ~op_mode & cmd_age_q[2] & sck_rise;
      strobe_q   <= strobe;
    end
  end

  // led pin is released in command mode so the host can clock it
  assign o_led_sck_o    = led_q;
  assign o_led_sck_oe_n = ~op_mode;

  // open drain: pad level is always low, only the enable moves
  assign o_detect_out_n_o     = 1'b0;
  assign o_detect_out_n_oe_n  = op_mode ? ~det_active : so_q;
  assign o_reserve_out_n_o    = 1'b0;
  assign o_reserve_out_n_oe_n = ~res_active;

  assign o_cmd_mode        = ~op_mode;
  assign o_serial_in       = si_q;
  assign o_serial_clk_rise = sck_rise_q;
  assign o_pulse_strobe    = strobe_q;

endmodule : light_barrier_pulse_controller

// ===== hdl/light_barrier_cfg.svh
// constants for the light barrier pulse controller
`ifndef LIGHT_BARRIER_CFG_SVH
`define LIGHT_BARRIER_CFG_SVH

`define LB_CLK_MHZ        100
`define LB_REF_OSC_MHZ    32
`define LB_PULSE_US_MIN   1
`define LB_PULSE_US_MAX   8
`define LB_PER_US_MIN     5
`define LB_PER_US_MAX     100000
`define LB_CNT_W          24
`define LB_FILT_W         16
`define LB_FILT_MAX       16'h8000
`define LB_INC_UNIT       1024
`define LB_INC_ZERO_W     32
`define LB_SYNC_STAGES    2

`endif

// ===== hdl/light_barrier_pkg.sv
// types shared by the light barrier pulse controller
package light_barrier_pkg;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'b00,
    ST_PULSE = 2'b01,
    ST_EVAL  = 2'b11
  } led_state_e;

  typedef logic [2:0] pulse_code_t;

endpackage : light_barrier_pkg

// ===== hdl/pulse_filter.sv
// weighted up/down pulse filter with latched detection state
`include "light_barrier_cfg.svh"

module pulse_filter
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_strobe,
  input  wire logic       i_valid,
  input  wire logic [4:0] i_inc_weight,
  input  wire logic [3:0] i_missing_weight,
  output logic            o_active,
  output logic [15:0]     o_count
);

  localparam logic [16:0] MAX17 = {1'b0, `LB_FILT_MAX};

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        act_q;
  logic [16:0] up_sum;
  logic [15:0] up_step;
  logic [15:0] dn_step;

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    // zero weight means the widest step
    if (i_inc_weight == 5'h00)
      up_step = 16'(`LB_INC_ZERO_W * `LB_INC_UNIT);
    else
      up_step = 16'(32'(i_inc_weight) * `LB_INC_UNIT);
    dn_step = 16'h0001 << i_missing_weight;
    up_sum  = {1'b0, cnt_q} + {1'b0, up_step};
    cnt_d   = cnt_q;
    if (i_strobe)
    begin
      if (i_valid)
        cnt_d = (up_sum >= MAX17) ? `LB_FILT_MAX : up_sum[15:0];
      else
        cnt_d = (cnt_q <= dn_step) ? 16'h0000 : cnt_q - dn_step;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      cnt_q <= 16'h0000;
    else
      cnt_q <= cnt_d;
  end

  // hysteresis: only the two limits move the output
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      act_q <= 1'b0;
    else if (cnt_d == `LB_FILT_MAX)
      act_q <= 1'b1;
    else if (cnt_d == 16'h0000)
      act_q <= 1'b0;
  end

  assign o_active = act_q;
  assign o_count  = cnt_q;

endmodule : pulse_filter

// ===== verif/lb_host_model.sv
// host side: mode select, enable or serial data, serial clock
module lb_host_model
(
  input  wire logic i_clk,
  output logic      o_cs_n,
  output logic      o_en_si,
  output logic      o_sck,
  output logic      o_sck_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    o_cs_n = 1'b1;
    o_en_si = 1'b0;
    o_sck = 1'b1;
    o_sck_drv = 1'b0;
  end
  task automatic en_pulse();
    @(posedge i_clk);
    o_en_si <= 1'b1;
    repeat (2) @(posedge i_clk);
    o_en_si <= 1'b0;
  endtask : en_pulse
  task automatic cmd_start();
    @(posedge i_clk);
    o_sck_drv <= 1'b1;
    o_cs_n <= 1'b0;
  endtask : cmd_start
  // four cycles a phase gives the 80 ns link period
  task automatic sclk(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk);
      o_sck <= 1'b0;
      o_en_si <= i[0];
      repeat (4) @(posedge i_clk);
      o_sck <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
  endtask : sclk
  task automatic cmd_stop();
    @(posedge i_clk);
    o_en_si <= 1'b0;
    o_cs_n <= 1'b1;
    @(posedge i_clk);
    o_sck_drv <= 1'b0;
  endtask : cmd_stop
endmodule : lb_host_model

// ===== verif/lb_pulse_checker.sv
// port assertions for the light barrier pulse controller
module lb_pulse_checker
#(
  parameter int CYC_PER_US = 100
)
(
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_cs_n,
  input wire logic        i_en_si,
  input wire logic        i_standalone,
  input wire logic [2:0]  i_led_pulse_len,
  input wire logic [16:0] i_scan_period,
  input wire logic [4:0]  i_inc_weight,
  input wire logic [3:0]  i_missing_weight,
  input wire logic        i_detect_hit,
  input wire logic        o_led_sck_o,
  input wire logic        o_led_sck_oe_n,
  input wire logic        o_detect_out_n_o,
  input wire logic        o_detect_out_n_oe_n,
  input wire logic        o_cmd_mode,
  input wire logic        o_pulse_strobe,
  input wire logic        o_serial_clk_rise
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        led_q;
  logic        seen_q;
  logic [23:0] hi_q;
  logic [23:0] gap_q;
  logic        rise;
  assign rise = o_led_sck_o && !led_q;
  // gap saturates so the first pulse after reset counts as well spaced
  always_ff @(posedge i_clk)
  begin
    led_q <= i_rstn && o_led_sck_o;
    hi_q <= (i_rstn && o_led_sck_o) ? hi_q + 24'h1 : 24'h0;
    gap_q <= !i_rstn ? 24'hFFFFFF : rise ? 24'h1 : gap_q + {23'h0, gap_q != 24'hFFFFFF};
    seen_q <= i_rstn && i_standalone && !o_cmd_mode && $stable(i_scan_period) && (seen_q || rise);
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_cs_low; !i_cs_n [*4]; endsequence
  sequence s_op; !o_cmd_mode [*3]; endsequence
  property p_cmd; s_cs_low |-> o_cmd_mode && o_led_sck_oe_n && !o_led_sck_o; endproperty
  a_cmd: assert property (p_cmd) else $error("command mode");
  property p_od; !o_detect_out_n_o; endproperty
  a_od: assert property (p_od) else $error("driven high");
  property p_len; $fell(o_led_sck_o) && !o_cmd_mode |-> hi_q == (i_led_pulse_len + 1) * CYC_PER_US; endproperty
  a_len: assert property (p_len) else $error("pulse length");
  property p_per; rise && seen_q && i_standalone |-> gap_q == i_scan_period * CYC_PER_US; endproperty
  a_per: assert property (p_per) else $error("scan period");
  property p_ctl; $rose(i_en_si) && !i_standalone && !o_cmd_mode && gap_q > 13 |-> ##[3:5] $rose(o_led_sck_o); endproperty
  a_ctl: assert property (p_ctl) else $error("no pulse");
  property p_fill; o_pulse_strobe && !o_cmd_mode && $past(i_detect_hit) && i_inc_weight == 5'h00 |-> !o_detect_out_n_oe_n; endproperty
  a_fill: assert property (p_fill) else $error("no detect");
  property p_drain; o_pulse_strobe && !o_cmd_mode && !$past(i_detect_hit) && i_missing_weight == 4'hF |-> o_detect_out_n_oe_n; endproperty
  a_drain: assert property (p_drain) else $error("no release");
  property p_hold; s_op ##0 !o_pulse_strobe |-> $stable(o_detect_out_n_oe_n); endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_sck; o_serial_clk_rise |-> $past(o_cmd_mode) && $past(o_cmd_mode, 4); endproperty
  a_sck: assert property (p_sck) else $error("serial clock edge outside command mode");
endmodule : lb_pulse_checker
bind light_barrier_pulse_controller lb_pulse_checker #(.CYC_PER_US(CYC_PER_US)) u_chk
(
  .i_clk, .i_rstn, .i_cs_n, .i_en_si, .i_standalone, .i_led_pulse_len, .i_scan_period, .i_inc_weight,
  .i_missing_weight, .i_detect_hit, .o_led_sck_o, .o_led_sck_oe_n, .o_detect_out_n_o,
  .o_detect_out_n_oe_n, .o_cmd_mode, .o_pulse_strobe, .o_serial_clk_rise
);

// ===== verif/light_barrier_pulse_controller_tb_top.sv
// self-checking bench for the light barrier pulse controller
module light_barrier_pulse_controller_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CPU = 1;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_standalone = 1'b0;
  logic [2:0]  i_led_pulse_len = 3'h0;
  logic [16:0] i_scan_period = 17'h00005;
  logic [4:0]  i_inc_weight = 5'h00;
  logic [3:0]  i_missing_weight = 4'hF;
  logic        i_detect_hit = 1'b0;
  logic        i_reserve_hit = 1'b0;
  logic        i_serial_out = 1'b1;
  logic        i_cs_n, i_en_si, i_led_sck_i, sck, sck_drv, o_led_sck_o, o_led_sck_oe_n, o_detect_out_n_o;
  logic        o_detect_out_n_oe_n, o_reserve_out_n_o, o_reserve_out_n_oe_n, o_cmd_mode, o_serial_in;
  logic        o_serial_clk_rise, o_pulse_strobe;
  logic        pin_q = 1'b0;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n_rise = 0;
  int          n;
  always #5 i_clk = ~i_clk;
  // a released pin wanders rather than holding its last level
  assign i_led_sck_i = !o_led_sck_oe_n ? o_led_sck_o : (sck_drv ? sck : ~pin_q);
  light_barrier_pulse_controller #(.CYC_PER_US(CPU)) dut
  (
    .i_clk, .i_rstn, .i_cs_n, .i_en_si, .i_led_sck_i, .o_led_sck_o, .o_led_sck_oe_n, .o_detect_out_n_o,
    .o_detect_out_n_oe_n, .o_reserve_out_n_o, .o_reserve_out_n_oe_n, .i_standalone, .i_led_pulse_len,
    .i_scan_period, .i_inc_weight, .i_missing_weight, .i_detect_hit, .i_reserve_hit, .i_serial_out,
    .o_cmd_mode, .o_serial_in, .o_serial_clk_rise, .o_pulse_strobe
  );
  lb_host_model host (.i_clk, .o_cs_n(i_cs_n), .o_en_si(i_en_si), .o_sck(sck), .o_sck_drv(sck_drv));
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out
  always @(posedge i_clk)
  begin
    pin_q <= i_led_sck_i;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      close_out();
    end
  end
  always @(negedge i_clk)
    if (o_serial_clk_rise === 1'b1)
      n_rise++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic pulse(input logic h, output int len);
    int t;
    repeat (12) @(posedge i_clk);
    i_detect_hit <= h;
    i_reserve_hit <= h;
    host.en_pulse();
    len = 0;
    t = 0;
    while (o_pulse_strobe !== 1'b1 && t < 40)
    begin
      @(negedge i_clk);
      t++;
      len += (o_led_sck_o === 1'b1);
    end
  endtask : pulse
  task automatic step(input logic h, input logic [1:0] exp);
    pulse(h, n);
    chk({o_detect_out_n_oe_n, o_reserve_out_n_oe_n}, exp);
  endtask : step
  task automatic rise_gap(output int g);
    int t;
    int r;
    int last;
    logic pv;
    t = 0;
    r = 0;
    last = 0;
    pv = 1'b1;
    while (r < 3 && t < 200)
    begin
      @(negedge i_clk);
      t++;
      if (o_led_sck_o === 1'b1 && !pv)
      begin
        r++;
        g = t - last;
        last = t;
      end
      pv = o_led_sck_o;
    end
  endtask : rise_gap
  initial
  begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      @(posedge i_clk);
      i_led_pulse_len <= 3'(c);
      pulse(1'b0, n);
      chk(n, (c + 1) * CPU);
    end
    step(1'b1, 2'b00);
    step(1'b0, 2'b11);
    @(posedge i_clk);
    i_inc_weight <= 5'h10;
    i_missing_weight <= 4'hE;
    step(1'b1, 2'b11);
    step(1'b1, 2'b00);
    step(1'b0, 2'b00);
    step(1'b0, 2'b11);
    @(posedge i_clk);
    i_led_pulse_len <= 3'h0;
    i_standalone <= 1'b1;
    for (int p = 5; p < 12; p += 6)
    begin
      @(posedge i_clk);
      i_scan_period <= 17'(p);
      fork
        host.en_pulse();
      join_none
      rise_gap(n);
      chk(n, p * CPU);
    end
    @(posedge i_clk);
    i_standalone <= 1'b0;
    i_serial_out <= 1'b0;
    host.cmd_start();
    repeat (4) @(negedge i_clk);
    chk({o_cmd_mode, o_led_sck_oe_n, o_detect_out_n_oe_n, o_serial_in}, 4'hC);
    n_rise = 0;
    host.sclk(6);
    repeat (6) @(negedge i_clk);
    chk(n_rise, 6);
    chk(o_serial_in, 1'b1);
    @(posedge i_clk);
    i_serial_out <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk(o_detect_out_n_oe_n, 1'b1);
    host.cmd_stop();
    pulse(1'b0, n);
    chk({o_cmd_mode, n[3:0]}, 5'h01);
    chk(o_reserve_out_n_o, 1'b0);
    close_out();
  end
endmodule : light_barrier_pulse_controller_tb_top
